// ### hw/empsb_bus_seq.sv
// empsb_bus_seq: external memory bus sequencer with page mode and data stretch
// assumes a single system clock, core requests synchronous to it, external latch on port_zero and port_two
//
// Contract
// [R1] stretch code zero adds nothing to external data accesses
// [R2] codes one to three add one to three stretch cycles
// [R3] first stretch setting: one clock extra setup/float, one extra hold
// [R4] codes 4-7: one stretch cycle widens ale, one adds hold; on a page hit with no ale the setup is widened instead
// [R5] codes 0-3 give 0-3 cycles, codes 4-7 give 7-10 cycles
// [R6] each stretch cycle is four clocks; new code applies to later accesses
// [R7] non-page external cycle four clocks, internal cycle one clock
// [R8] page enable selects page operation, clear returns to non-page bus
// [R9] page select sets hit/miss clocks 1/2, 2/4, 4/8, 2/4
// [R10] select 11 speeds fetches only; data accesses take four clocks
// [R11] mode register written only through timed access, else ignored
// [R12] page mode 1 fetch floats port_zero, opcode latched at strobe end
// [R13] page mode 1 data: port_zero floats for read, drives for write
// [R14] upper byte change gives page miss of 2, 4 or 8 clocks
// [R15] same upper byte gives page hit of 1, 2 or 4 clocks
// [R16] hit: port_two drives low byte, strobes active, no ale
// [R17] miss first half: upper byte, ale, strobes off, port_zero floats
// [R18] last upper byte stored; first access after reset misses
// [R19] select 00: data move and following fetch are forced misses
// [R20] select 01: misses only from upper byte changes
// [R21] bus 2: upper byte with data on port_two, low byte on port_zero
// [R22] stretch affects only external data accesses
`timescale 1ns/1ps
`default_nettype none
`include "empsb_cfg.svh"

module empsb_bus_seq
  import empsb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // mode register write
  input wire logic address_control_reg_wr,
  input wire logic [7:0] address_control_reg_wdata,
  input wire logic timed_access_open,
  input wire logic [2:0] stretch_field,
  // status
  output logic page_mode_enable,
  output logic page_select_hi,
  output logic page_select_lo,
  output logic page_miss,
  // core request
  input wire logic req_valid,
  output logic req_ready,
  input wire empsb_kind_t req_kind,
  input wire logic req_internal,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  // core response
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  // port zero
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_zero_out,
  output logic port_zero_oe_n,
  // port two
  input wire logic [7:0] port_two_in,
  output logic [7:0] port_two_out,
  output logic port_two_oe_n,
  // strobes
  output logic ale,
  output logic program_store_strobe_n,
  output logic read_strobe_n,
  output logic write_strobe_n
);

  // ****************************************
  // mode register
  // ****************************************
  logic [7:0] address_control_reg_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      address_control_reg_q <= `EMPSB_ADDRESS_CONTROL_REG_RESET;
    end else if (ce && address_control_reg_wr && timed_access_open) begin // [R11]
      address_control_reg_q <= address_control_reg_wdata;
    end
  end

  logic [1:0] cfg_sel;
  assign page_mode_enable = address_control_reg_q[`EMPSB_ADDRESS_CONTROL_REG_EN_BIT];
  assign page_select_hi = address_control_reg_q[`EMPSB_ADDRESS_CONTROL_REG_SELHI_BIT];
  assign page_select_lo = address_control_reg_q[`EMPSB_ADDRESS_CONTROL_REG_SELLO_BIT];
  assign cfg_sel = {page_select_hi, page_select_lo};

  // ****************************************
  // page tracking
  // ****************************************
  empsb_state_t state_q;
  logic accept;
  logic ext_accept;
  logic is_data_req;
  logic [7:0] last_hi_q;
  logic page_valid_q;
  logic force_miss_q;
  logic miss_d;

  assign req_ready = (state_q == st_idle);
  assign accept = ce && req_valid && req_ready;
  assign ext_accept = accept && !req_internal;
  assign is_data_req = (req_kind != empsb_fetch);

  always_comb begin
    miss_d = !page_valid_q || (req_addr[15:8] != last_hi_q); // [R14] [R15] [R18] [R20]
    if (page_mode_enable && cfg_sel == `EMPSB_SEL_ONE && (is_data_req || force_miss_q)) begin
      miss_d = 1'b1; // [R19]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_hi_q <= `EMPSB_RESET_BYTE;
      page_valid_q <= 1'b0;
    end else if (ext_accept) begin
      last_hi_q <= req_addr[15:8]; // [R18]
      page_valid_q <= 1'b1;
    end
  end

  // a data move in select 00 makes the next fetch miss too
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_miss_q <= 1'b0;
    end else if (ext_accept) begin
      force_miss_q <= page_mode_enable && cfg_sel == `EMPSB_SEL_ONE && is_data_req; // [R19]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_miss <= 1'b0;
    end else if (ext_accept) begin
      page_miss <= miss_d;
    end
  end

  // ****************************************
  // cycle plan
  // ****************************************
  logic [5:0] ale_len;
  logic [5:0] setup_len;
  logic [5:0] strb_len;
  logic [5:0] hold_len;
  logic paged;

  empsb_cycle_plan u_plan (
    .page_en (page_mode_enable),
    .page_sel (cfg_sel),
    .stretch (stretch_field),
    .kind (req_kind),
    .miss (miss_d),
    .ale_len (ale_len),
    .setup_len (setup_len),
    .strb_len (strb_len),
    .hold_len (hold_len),
    .paged (paged)
  );

  // ****************************************
  // access registers
  // ****************************************
  empsb_kind_t kind_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic paged_q;
  logic bus2_q;
  logic [5:0] setup_len_q;
  logic [5:0] strb_len_q;
  logic [5:0] hold_len_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kind_q <= empsb_fetch;
      addr_q <= 16'h0000;
      wdata_q <= `EMPSB_RESET_BYTE;
      paged_q <= 1'b0;
      bus2_q <= 1'b0;
      setup_len_q <= 6'h00;
      strb_len_q <= 6'h00;
      hold_len_q <= 6'h00;
    end else if (ext_accept) begin
      kind_q <= req_kind;
      addr_q <= req_addr;
      wdata_q <= req_wdata;
      paged_q <= paged;
      bus2_q <= page_mode_enable && cfg_sel == `EMPSB_SEL_BUS2; // [R21]
      setup_len_q <= setup_len;
      strb_len_q <= strb_len;
      hold_len_q <= hold_len;
    end
  end

  // ****************************************
  // phase sequencer
  // ****************************************
  logic [5:0] cnt_q;
  logic last_clk;
  logic access_end;

  assign last_clk = (cnt_q == 6'h01);
  assign access_end = ce && last_clk &&
    ((state_q == st_strb && hold_len_q == 6'h00) || state_q == st_hold);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= st_idle;
      cnt_q <= 6'h00;
    end else if (ce) begin
      case (state_q)
        st_idle: begin
          if (accept && req_internal) begin
            state_q <= st_intl; // [R7] [R22]
            cnt_q <= 6'h01;
          end else if (accept && ale_len != 6'h00) begin
            state_q <= st_ale;
            cnt_q <= ale_len;
          end else if (accept && setup_len != 6'h00) begin
            state_q <= st_setup;
            cnt_q <= setup_len;
          end else if (accept) begin
            state_q <= st_strb;
            cnt_q <= strb_len;
          end
        end
        st_ale: begin
          if (!last_clk) begin
            cnt_q <= cnt_q - 6'h01;
          end else if (setup_len_q != 6'h00) begin
            state_q <= st_setup;
            cnt_q <= setup_len_q;
          end else begin
            state_q <= st_strb;
            cnt_q <= strb_len_q;
          end
        end
        st_setup: begin
          if (!last_clk) begin
            cnt_q <= cnt_q - 6'h01;
          end else begin
            state_q <= st_strb;
            cnt_q <= strb_len_q;
          end
        end
        st_strb: begin
          if (!last_clk) begin
            cnt_q <= cnt_q - 6'h01;
          end else if (hold_len_q != 6'h00) begin
            state_q <= st_hold;
            cnt_q <= hold_len_q;
          end else begin
            state_q <= st_idle;
            cnt_q <= 6'h00;
          end
        end
        st_hold: begin
          if (!last_clk) begin
            cnt_q <= cnt_q - 6'h01;
          end else begin
            state_q <= st_idle;
            cnt_q <= 6'h00;
          end
        end
        st_intl: begin
          state_q <= st_idle;
          cnt_q <= 6'h00;
        end
        default: begin
          state_q <= st_idle;
          cnt_q <= 6'h00;
        end
      endcase
    end
  end

  // ****************************************
  // response
  // ****************************************
  logic rsp_valid_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid_q <= 1'b0;
    end else if (ce) begin
      rsp_valid_q <= access_end || state_q == st_intl;
    end
  end
  assign rsp_valid = rsp_valid_q;

  // read data taken on the clock that ends the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_rdata <= `EMPSB_RESET_BYTE;
    end else if (ce && state_q == st_strb && last_clk && kind_q != empsb_write) begin
      rsp_rdata <= bus2_q ? port_two_in : port_zero_in; // [R12] [R21]
    end
  end

  // ****************************************
  // pins
  // ****************************************
  logic busy;
  logic data_phase;
  logic drv_wdata;

  assign busy = (state_q != st_idle) && (state_q != st_intl);
  assign data_phase = (state_q == st_strb) || (state_q == st_hold);
  assign drv_wdata = (kind_q == empsb_write) && data_phase;

  assign ale = (state_q == st_ale); // [R16] [R17]
  assign program_store_strobe_n = !(state_q == st_strb && kind_q == empsb_fetch);
  assign read_strobe_n = !(state_q == st_strb && kind_q == empsb_read);
  assign write_strobe_n = !(state_q == st_strb && kind_q == empsb_write);

  always_comb begin
    port_zero_out = wdata_q;
    port_zero_oe_n = 1'b1;
    port_two_out = addr_q[15:8];
    port_two_oe_n = 1'b1;
    if (busy && bus2_q) begin
      port_zero_out = addr_q[7:0]; // [R21]
      port_zero_oe_n = 1'b0;
      if (state_q == st_ale) begin
        port_two_oe_n = 1'b0;
      end else if (drv_wdata) begin
        port_two_out = wdata_q;
        port_two_oe_n = 1'b0;
      end
    end else if (busy && paged_q) begin
      port_two_out = (state_q == st_ale) ? addr_q[15:8] : addr_q[7:0]; // [R16] [R17]
      port_two_oe_n = 1'b0;
      port_zero_oe_n = !drv_wdata; // [R12] [R13] [R17]
    end else if (busy) begin
      port_two_oe_n = 1'b0; // [R8]
      if (state_q == st_ale) begin
        port_zero_out = addr_q[7:0];
        port_zero_oe_n = 1'b0;
      end else begin
        port_zero_oe_n = !drv_wdata; // [R3]
      end
    end
  end

endmodule
`default_nettype wire

// ### hw/empsb_cfg.svh
// empsb_cfg.svh: constants for the external memory page/stretch bus sequencer
// assumes inclusion by bare name from the design modules
`ifndef EMPSB_CFG_SVH
`define EMPSB_CFG_SVH

// ****************************************
// address control register layout
// ****************************************
`define EMPSB_ADDRESS_CONTROL_REG_EN_BIT 7
`define EMPSB_ADDRESS_CONTROL_REG_SELHI_BIT 6
`define EMPSB_ADDRESS_CONTROL_REG_SELLO_BIT 5
`define EMPSB_ADDRESS_CONTROL_REG_RESET 8'h00

// ****************************************
// page select codes
// ****************************************
`define EMPSB_SEL_ONE 2'h0
`define EMPSB_SEL_TWO 2'h1
`define EMPSB_SEL_FOUR 2'h2
`define EMPSB_SEL_BUS2 2'h3

// ****************************************
// timing counts in system clocks, stretch code offset and reset byte
// ****************************************
`define EMPSB_HIT_SEL0 6'h01
`define EMPSB_HIT_SEL1 6'h02
`define EMPSB_HIT_SEL2 6'h04
`define EMPSB_HIT_SEL3 6'h02
`define EMPSB_NP_ALE 6'h01
`define EMPSB_NP_STRB 6'h02
`define EMPSB_NP_HOLD 6'h01
`define EMPSB_STRETCH_CLKS 6'h04
`define EMPSB_SMALL_SETUP 6'h01
`define EMPSB_SMALL_HOLD 6'h01
`define EMPSB_BIG_OFFSET 4'h3
`define EMPSB_RESET_BYTE 8'h00

`endif

// ### hw/empsb_pkg.sv
// empsb_pkg: types shared by the bus sequencer and its cycle planner
// assumes empsb_cfg.svh is on the include path
package empsb_pkg;

  typedef enum logic [1:0] {
    empsb_fetch = 2'h0,
    empsb_read = 2'h1,
    empsb_write = 2'h2
  } empsb_kind_t;

  typedef enum logic [5:0] {
    st_idle = 6'h01,
    st_ale = 6'h02,
    st_setup = 6'h04,
    st_strb = 6'h08,
    st_hold = 6'h10,
    st_intl = 6'h20
  } empsb_state_t;

endpackage

// ### hw/empsb_cycle_plan.sv
// empsb_cycle_plan: phase lengths of one external access
// assumes a purely combinational use by the sequencer at request accept
`timescale 1ns/1ps
`default_nettype none
`include "empsb_cfg.svh"

module empsb_cycle_plan
  import empsb_pkg::*;
(
  // configuration
  input wire logic page_en,
  input wire logic [1:0] page_sel,
  input wire logic [2:0] stretch,
  // access
  input wire empsb_kind_t kind,
  input wire logic miss,
  // plan
  output logic [5:0] ale_len,
  output logic [5:0] setup_len,
  output logic [5:0] strb_len,
  output logic [5:0] hold_len,
  output logic paged
);

  logic is_data;
  logic [5:0] hit_len;
  logic [3:0] ncyc;
  logic [5:0] nclk;

  always_comb begin
    is_data = (kind != empsb_fetch);
    case (page_sel) // [R9]
      `EMPSB_SEL_ONE: hit_len = `EMPSB_HIT_SEL0;
      `EMPSB_SEL_TWO: hit_len = `EMPSB_HIT_SEL1;
      `EMPSB_SEL_FOUR: hit_len = `EMPSB_HIT_SEL2;
      default: hit_len = `EMPSB_HIT_SEL3;
    endcase
    // codes 4..7 map to 7..10 stretch cycles
    ncyc = stretch[2] ? ({1'b0, stretch} + `EMPSB_BIG_OFFSET) : {1'b0, stretch}; // [R5]
    nclk = 6'(ncyc * `EMPSB_STRETCH_CLKS); // [R6]
    // bus structure 2 runs data cycles with non-page timing
    paged = page_en && !(page_sel == `EMPSB_SEL_BUS2 && is_data); // [R8] [R10] [R21]
    if (paged) begin
      ale_len = miss ? hit_len : 6'h00; // [R14] [R15] [R17]
      setup_len = 6'h00;
      strb_len = hit_len; // [R16] [R19] [R20]
      hold_len = 6'h00;
    end else begin
      ale_len = `EMPSB_NP_ALE; // [R7]
      setup_len = 6'h00;
      strb_len = `EMPSB_NP_STRB;
      hold_len = `EMPSB_NP_HOLD;
    end
    // only external data accesses stretch
    if (is_data && stretch != 3'h0) begin // [R1] [R22]
      if (!stretch[2]) begin
        setup_len = setup_len + `EMPSB_SMALL_SETUP; // [R3]
        hold_len = hold_len + `EMPSB_SMALL_HOLD; // [R3]
        strb_len = strb_len + nclk - `EMPSB_SMALL_SETUP - `EMPSB_SMALL_HOLD; // [R2]
      end else begin
        if (ale_len != 6'h00) begin
          ale_len = ale_len + `EMPSB_STRETCH_CLKS; // [R4]
        end else begin
          setup_len = setup_len + `EMPSB_STRETCH_CLKS;
        end
        hold_len = hold_len + `EMPSB_STRETCH_CLKS; // [R4]
        strb_len = strb_len + nclk - `EMPSB_STRETCH_CLKS - `EMPSB_STRETCH_CLKS;
      end
    end
  end

endmodule
`default_nettype wire

// ### sim/empsb_bus_seq_sva.sv
// empsb_bus_seq_sva: port checker for the bus sequencer
// assumes bind onto empsb_bus_seq, one clock domain
`timescale 1ns/1ps
`default_nettype none
module empsb_bus_seq_sva
  import empsb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // mode
  input wire logic address_control_reg_wr,
  input wire logic [7:0] address_control_reg_wdata,
  input wire logic timed_access_open,
  input wire logic page_mode_enable,
  input wire logic page_select_hi,
  input wire logic page_select_lo,
  input wire logic page_miss,
  // core side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire empsb_kind_t req_kind,
  input wire logic req_internal,
  input wire logic rsp_valid,
  // pins
  input wire logic port_zero_oe_n,
  input wire logic ale,
  input wire logic program_store_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic acc = ce && req_valid && req_ready;
  wire logic ext = acc && !req_internal;
  wire logic b1 = !(page_mode_enable && page_select_hi && page_select_lo);
  property p_ale_quiet;
    ale |-> program_store_strobe_n && read_strobe_n && write_strobe_n;
  endproperty
  a_ale_quiet: assert property (p_ale_quiet) else $error("strobe in ale");
  property p_ale_float;
    ale && page_mode_enable && b1 |-> port_zero_oe_n;
  endproperty
  a_ale_float: assert property (p_ale_float) else $error("p0 driven in ale");
  property p_fetch_float;
    !program_store_strobe_n && b1 |-> port_zero_oe_n;
  endproperty
  a_fetch_float: assert property (p_fetch_float) else $error("p0 driven in fetch");
  property p_read_float;
    !read_strobe_n && b1 |-> port_zero_oe_n;
  endproperty
  a_read_float: assert property (p_read_float) else $error("p0 driven in read");
  property p_write_drive;
    !write_strobe_n && b1 |-> !port_zero_oe_n;
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("p0 float in write");
  property p_address_control_reg_hold;
    address_control_reg_wr && !timed_access_open |=> $stable({page_mode_enable, page_select_hi, page_select_lo});
  endproperty
  a_address_control_reg_hold: assert property (p_address_control_reg_hold) else $error("locked write took");
  property p_address_control_reg_take;
    ce && address_control_reg_wr && timed_access_open |=> page_mode_enable == $past(address_control_reg_wdata[7]);
  endproperty
  a_address_control_reg_take: assert property (p_address_control_reg_take) else $error("mode write lost");
  property p_internal;
    acc && req_internal |=> !req_ready && !ale && program_store_strobe_n ##1 rsp_valid;
  endproperty
  a_internal: assert property (p_internal) else $error("internal timing");
  property p_np_fetch;
    ext && !page_mode_enable && req_kind == empsb_fetch |=> ale ##4 rsp_valid;
  endproperty
  a_np_fetch: assert property (p_np_fetch) else $error("non-page fetch timing");
  property p_page_ale;
    ext && page_mode_enable && req_kind == empsb_fetch |=> ale == page_miss;
  endproperty
  a_page_ale: assert property (p_page_ale) else $error("ale vs miss");
  c_miss: cover property (page_mode_enable && ale);
  c_write: cover property (!write_strobe_n);
  c_locked: cover property (address_control_reg_wr && !timed_access_open);
endmodule
bind empsb_bus_seq empsb_bus_seq_sva u_sva (.*);
`default_nettype wire

// ### sim/empsb_ext_mem.sv
// empsb_ext_mem: address latch and memory behind the sequencer
// assumes the sequencer mode bits give the bus structure
`timescale 1ns/1ps
`default_nettype none
module empsb_ext_mem (
  // clock
  input wire logic clk,
  // sequencer pins
  input wire logic ale,
  input wire logic program_store_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] port_zero_out,
  input wire logic port_zero_oe_n,
  input wire logic [7:0] port_two_out,
  input wire logic port_two_oe_n,
  // mode bits
  input wire logic page_mode_enable,
  input wire logic page_select_hi,
  input wire logic page_select_lo,
  // wires and write capture
  output logic [7:0] port_zero_in,
  output logic [7:0] port_two_in,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data
);
  logic [7:0] hi_q = 8'h00;
  logic [7:0] lo_q = 8'h00;
  logic [7:0] z_q = 8'h00;
  logic [7:0] t_q = 8'h00;
  logic [15:0] addr;
  logic [7:0] rd;
  logic m2;
  logic strb;
  assign m2 = page_mode_enable && page_select_hi && page_select_lo;
  assign strb = !program_store_strobe_n || !read_strobe_n;
  assign addr = {hi_q, page_mode_enable && !m2 ? port_two_out : (m2 ? port_zero_out : lo_q)};
  assign rd = addr[15:8] ^ {addr[3:0], addr[7:4]};
  // released lines flip each cycle
  assign port_zero_in = !port_zero_oe_n ? port_zero_out : (strb && !m2 ? rd : ~z_q);
  assign port_two_in = !port_two_oe_n ? port_two_out : (strb && m2 ? rd : ~t_q);
  always_ff @(posedge clk) begin
    z_q <= port_zero_in;
    t_q <= port_two_in;
    if (ale) begin
      hi_q <= port_two_out;
      lo_q <= port_zero_out;
    end
    if (!write_strobe_n) begin
      wr_addr <= addr;
      wr_data <= m2 ? port_two_out : port_zero_out;
    end
  end
endmodule
`default_nettype wire

// ### sim/empsb_bus_seq_test.sv
// empsb_bus_seq_test: self-checking bench for the bus sequencer
// assumes empsb_ext_mem on the far side, checker bound by its own file
`timescale 1ns/1ps
`default_nettype none
module empsb_bus_seq_test
  import empsb_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic address_control_reg_wr = 1'b0;
  logic timed_access_open = 1'b0;
  logic [7:0] address_control_reg_wdata = 8'h00;
  logic [2:0] stretch_field = 3'h0;
  logic req_valid = 1'b0;
  logic req_internal = 1'b0;
  empsb_kind_t req_kind = empsb_fetch;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic page_mode_enable, page_select_hi, page_select_lo, page_miss, req_ready, rsp_valid;
  logic ale, program_store_strobe_n, read_strobe_n, write_strobe_n;
  logic port_zero_oe_n, port_two_oe_n;
  logic [7:0] rsp_rdata, port_zero_in, port_zero_out, port_two_in, port_two_out, wr_data;
  logic [15:0] wr_addr;
  int error_cnt = 0;
  int checks = 0;
  int seed = 70;
  int r;
  logic first_q = 1'b1;
  logic pd_q = 1'b0;
  logic [7:0] hi_q = 8'h00;
  empsb_bus_seq dut (.*);
  empsb_ext_mem mem (.*);
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic set_mode(input logic pe, input logic [1:0] sel, input logic ta);
    logic [2:0] old;
    old = {page_mode_enable, page_select_hi, page_select_lo};
    address_control_reg_wr = 1'b1;
    timed_access_open = ta;
    address_control_reg_wdata = {pe, sel, 5'($random(seed))};
    @(negedge clk);
    address_control_reg_wr = 1'b0;
    @(negedge clk);
    chk(16'({page_mode_enable, page_select_hi, page_select_lo}), 16'(ta ? {pe, sel} : old));
  endtask
  task automatic acc(input empsb_kind_t k, input logic in, input logic [15:0] a,
                     input logic [2:0] st);
    int n, ln, h;
    logic dt, pe, miss;
    logic [1:0] sel;
    logic [7:0] wd;
    dt = k != empsb_fetch;
    pe = page_mode_enable;
    sel = {page_select_hi, page_select_lo};
    wd = 8'($random(seed));
    miss = first_q || a[15:8] != hi_q || (pe && sel == 2'h0 && (dt || pd_q));
    n = st < 4 ? st : st + 3;
    h = sel == 2'h0 ? 1 : (sel == 2'h2 ? 4 : 2);
    if (in) ln = 2;
    else if (!pe || (sel == 2'h3 && dt)) ln = 5 + (dt ? 4 * n : 0);
    else ln = 1 + (miss ? 2 * h : h) + (dt ? 4 * n : 0);
    req_valid = 1'b1;
    req_kind = k;
    req_internal = in;
    req_addr = a;
    req_wdata = wd;
    stretch_field = st;
    n = 0;
    do begin
      @(negedge clk);
      if (n == 0) req_valid = 1'b0;
      n++;
    end while (!rsp_valid && n < 200);
    chk(16'(n), 16'(ln));
    if (n >= 200) tally_and_finish();
    if (!in) begin
      chk(16'(page_miss), 16'(miss));
      if (k == empsb_write) begin
        chk(wr_addr, a);
        chk(16'(wr_data), 16'(wd));
      end else begin
        chk(16'(rsp_rdata), 16'(a[15:8] ^ {a[3:0], a[7:4]}));
      end
      first_q = 1'b0;
      hi_q = a[15:8];
      // only a data move made under select 00 forces the next fetch to miss
      pd_q = dt && pe && sel == 2'h0;
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    chk(16'({req_ready, page_mode_enable, ale, port_zero_oe_n, port_two_oe_n}), 16'h0013);
    resetn = 1'b1;
    set_mode(1'b1, 2'h1, 1'b0);
    set_mode(1'b1, 2'h1, 1'b1);
    // clock enable low: an unlocked mode write must not land
    ce = 1'b0;
    address_control_reg_wr = 1'b1;
    timed_access_open = 1'b1;
    address_control_reg_wdata = 8'h00;
    @(negedge clk);
    address_control_reg_wr = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    chk(16'({page_mode_enable, page_select_hi, page_select_lo}), 16'h0005);
    $display("test mode done");
    for (int m = 0; m < 5; m++) begin
      set_mode(m < 4, 2'(m), 1'b1);
      for (int s = 0; s < 8; s++) begin
        acc(empsb_fetch, 1'b0, 16'h1234, 3'(s));
        acc(empsb_read, 1'b0, 16'h12A0, 3'(s));
        acc(empsb_write, 1'b0, 16'h7700 + 16'(s), 3'(s));
        acc(empsb_fetch, 1'b0, 16'h7702, 3'(s));
        acc(empsb_read, 1'b1, 16'h0010, 3'(s));
      end
    end
    $display("test table done");
    repeat (300) begin
      r = $random(seed);
      if (r[14:12] == 3'h0) set_mode(r[15], r[17:16], r[18]);
      acc(empsb_kind_t'(r[1:0] == 2'h3 ? 2'h0 : r[1:0]), r[2] & r[3],
          {r[9:8] == 2'h0 ? 8'hC3 : 8'h3C, r[7:0]}, r[22:20]);
    end
    $display("test random done");
    resetn = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    first_q = 1'b1;
    pd_q = 1'b0;
    set_mode(1'b1, 2'h2, 1'b1);
    acc(empsb_fetch, 1'b0, {hi_q, 8'h11}, 3'h0);
    $display("test rereset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
